/* src/adc_conversion_sequencer.v */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_conversion_sequencer #(
  parameter ADDR_W = 8,
  parameter RES_W = 12
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // axi4-lite write channels
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read channels
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // analog core
  output reg analogPowerOn,
  output reg sampleHold,
  output reg [RES_W-1:0] dacCode,
  input wire compIn,
  output reg [3:0] extChanSel,
  output reg extChanConnect,
  output reg [3:0] intSourceSel,
  output reg intSourceConnect,
  output reg [1:0] refSourceSel,
  output reg pgaEnable,
  output reg [1:0] pgaInputSel,
  output reg [2:0] pgaGainSel,
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [3:0] chan_ff;
  reg fmt_ff;
  reg start_ff;
  reg power_ff;
  reg [2:0] divSel_ff;
  reg [3:0] srcSel_ff;
  reg [1:0] refSel_ff;
  reg [1:0] pgaIn_ff;
  reg [2:0] pgaGain_ff;
  reg [7:0] mask_ff;
  reg doneFlag_ff;
  reg abortFlag_ff;
  reg [7:0] resHigh_ff;
  reg [7:0] resLow_ff;
  // bus holding state
  reg awHeld_ff;
  reg wHeld_ff;
  reg [ADDR_W-1:0] wAddr_ff;
  reg [7:0] wByte_ff;
  reg wLane_ff;
  // conversion state
  reg busy_ff;
  reg [3:0] phase_ff;
  reg [6:0] divCnt_ff;
  reg [RES_W-1:0] code_ff;
  reg [RES_W-1:0] bitMask_ff;

  // ----------------------------------------
  // write channel handshakes
  // ----------------------------------------
  assign awready = ~awHeld_ff & ~bvalid;
  assign wready = ~wHeld_ff & ~bvalid;
  wire doWrite = awHeld_ff & wHeld_ff & ~bvalid;
  wire wrMapped = (wAddr_ff == `OFS_CTRL_ZERO) | (wAddr_ff == `OFS_CTRL_ONE) |
                  (wAddr_ff == `OFS_CTRL_TWO) | (wAddr_ff == `OFS_INT_MASK) |
                  (wAddr_ff == `OFS_RES_HIGH) | (wAddr_ff == `OFS_RES_LOW) |
                  (wAddr_ff == `OFS_INT_STATUS);
  wire wrCtrlZero = doWrite & wLane_ff & (wAddr_ff == `OFS_CTRL_ZERO);

  // address and data are caught independently, answered once both are in
  always @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      wAddr_ff <= {ADDR_W{1'b0}};
      wByte_ff <= 8'h00;
      wLane_ff <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        wAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wByte_ff <= wdata[7:0];
        wLane_ff <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign arready = ~rvalid;
  wire rdTake = arvalid & arready;
  wire rdClrStatus = rdTake & (araddr == `OFS_INT_STATUS);
  reg [7:0] rdByte;
  reg rdHit;

  // register read multiplexer
  always @* begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (araddr)
      `OFS_CTRL_ZERO: rdByte = {power_ff, busy_ff, start_ff, fmt_ff, chan_ff};
      `OFS_CTRL_ONE: rdByte = {srcSel_ff, 1'b0, divSel_ff};
      `OFS_CTRL_TWO: rdByte = {1'b0, pgaGain_ff, pgaIn_ff, refSel_ff};
      `OFS_RES_HIGH: rdByte = resHigh_ff;
      `OFS_RES_LOW: rdByte = resLow_ff;
      `OFS_INT_STATUS: rdByte = {6'h00, abortFlag_ff, doneFlag_ff};
      `OFS_INT_MASK: rdByte = mask_ff;
      default: rdHit = 1'b0;
    endcase
  end

  // one-cycle read answer, held until rready
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (rdTake) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rdByte};
      rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // start pulse decode
  // ----------------------------------------
  wire newStart = wByte_ff[`CZ_START_BIT];
  wire newPower = wByte_ff[`CZ_POWER_BIT];
  // high write resets the converter, falling write launches
  wire convReset = wrCtrlZero & newStart;
  wire launch = wrCtrlZero & start_ff & ~newStart & newPower;
  wire powerOff = wrCtrlZero ? ~newPower : ~power_ff;
  wire abortEvent = busy_ff & (convReset | powerOff);

  // ----------------------------------------
  // converter clock divider
  // ----------------------------------------
  wire [7:0] divSpan = 8'h01 << divSel_ff;
  wire [7:0] divSpanM1 = divSpan - 8'h01;
  wire convTick = busy_ff & (divCnt_ff == divSpanM1[6:0]);
  wire lastTick = convTick & (phase_ff == `LAST_PHASE);
  wire inConvert = phase_ff >= `SAMPLE_CLKS;
  wire [RES_W-1:0] decided = compIn ? code_ff : (code_ff & ~bitMask_ff);
  wire [RES_W-1:0] finalCode = decided;

  // control registers and conversion sequencing
  always @(posedge core_clk) begin
    if (!rst_n) begin
      chan_ff <= 4'h0;
      fmt_ff <= 1'b0;
      start_ff <= 1'b0;
      power_ff <= 1'b0;
      divSel_ff <= 3'h0;
      srcSel_ff <= 4'h0;
      refSel_ff <= 2'h0;
      pgaIn_ff <= 2'h0;
      pgaGain_ff <= 3'h0;
      mask_ff <= `INT_MASK_RST;
      busy_ff <= 1'b0;
      phase_ff <= 4'h0;
      divCnt_ff <= 7'h00;
      code_ff <= {RES_W{1'b0}};
      dacCode <= {RES_W{1'b0}};
      bitMask_ff <= {RES_W{1'b0}};
      resHigh_ff <= 8'h00;
      resLow_ff <= 8'h00;
    end else begin
      // software register writes
      if (doWrite && wLane_ff) begin
        case (wAddr_ff)
          `OFS_CTRL_ZERO: begin
            chan_ff <= wByte_ff[`CZ_CHAN_LSB +: 4];
            fmt_ff <= wByte_ff[`CZ_FMT_BIT];
            start_ff <= newStart;
            power_ff <= newPower;
          end
          `OFS_CTRL_ONE: begin
            divSel_ff <= wByte_ff[`CO_DIV_LSB +: 3];
            srcSel_ff <= wByte_ff[`CO_SRC_LSB +: 4];
          end
          `OFS_CTRL_TWO: begin
            refSel_ff <= wByte_ff[`CT_REF_LSB +: 2];
            pgaIn_ff <= wByte_ff[`CT_PGAIN_LSB +: 2];
            pgaGain_ff <= wByte_ff[`CT_PGAGAIN_LSB +: 3];
          end
          `OFS_INT_MASK: mask_ff <= wByte_ff;
          default: mask_ff <= mask_ff;
        endcase
      end
      // conversion sequence
      // dac code moves on the same edge as the trial, so the comparator
      // has a whole converter clock to settle even at divide by one
      if (convReset || powerOff) begin
        busy_ff <= 1'b0;
        phase_ff <= 4'h0;
        divCnt_ff <= 7'h00;
        bitMask_ff <= {RES_W{1'b0}};
      end else if (launch) begin
        busy_ff <= 1'b1;
        phase_ff <= 4'h0;
        divCnt_ff <= 7'h00;
        code_ff <= {RES_W{1'b0}};
        dacCode <= {RES_W{1'b0}};
        bitMask_ff <= {RES_W{1'b0}};
      end else if (busy_ff) begin
        divCnt_ff <= convTick ? 7'h00 : divCnt_ff + 7'h01;
        if (convTick) begin
          phase_ff <= phase_ff + 4'h1;
          if (phase_ff == `SAMPLE_CLKS - 4'h1) begin
            // sampling over, first trial is the top bit
            code_ff <= `RESULT_MSB_MASK;
            dacCode <= `RESULT_MSB_MASK;
            bitMask_ff <= `RESULT_MSB_MASK;
          end else if (inConvert) begin
            // keep or drop this bit, try the next one down
            code_ff <= decided | (bitMask_ff >> 1);
            dacCode <= decided | (bitMask_ff >> 1);
            bitMask_ff <= bitMask_ff >> 1;
          end
          if (lastTick) begin
            busy_ff <= 1'b0;
            code_ff <= finalCode;
            dacCode <= finalCode;
            if (fmt_ff) begin
              resHigh_ff <= {4'h0, finalCode[11:8]};
              resLow_ff <= finalCode[7:0];
            end else begin
              resHigh_ff <= finalCode[11:4];
              resLow_ff <= {finalCode[3:0], 4'h0};
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt status, set wins over read clear
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      doneFlag_ff <= 1'b0;
      abortFlag_ff <= 1'b0;
    end else begin
      doneFlag_ff <= lastTick | (doneFlag_ff & ~rdClrStatus);
      abortFlag_ff <= abortEvent | (abortFlag_ff & ~rdClrStatus);
    end
  end

  // needs global enable and per-event enable
  assign irq = mask_ff[`IM_GLOBAL_BIT] &
               ((doneFlag_ff & mask_ff[`IS_DONE_BIT]) |
                (abortFlag_ff & mask_ff[`IS_ABORT_BIT]));

  // ----------------------------------------
  // analog routing outputs
  // ----------------------------------------
  wire srcExternal = (srcSel_ff == 4'h0) | (srcSel_ff == 4'h4) |
                     (srcSel_ff[3:2] == 2'b11);
  wire refIsPga = refSel_ff == `REF_PGA_CODE;

  // registered drive to the analog core, connects, sample and amplifier enable off while unpowered, selects still driven
  always @(posedge core_clk) begin
    if (!rst_n) begin
      analogPowerOn <= 1'b0;
      sampleHold <= 1'b0;
      extChanSel <= 4'h0;
      extChanConnect <= 1'b0;
      intSourceSel <= 4'h0;
      intSourceConnect <= 1'b0;
      refSourceSel <= 2'h0;
      pgaEnable <= 1'b0;
      pgaInputSel <= 2'h0;
      pgaGainSel <= 3'h0;
    end else begin
      analogPowerOn <= power_ff;
      sampleHold <= busy_ff & ~inConvert;
      // dac code is driven by the sequencer itself
      extChanSel <= chan_ff;
      extChanConnect <= power_ff & srcExternal;
      intSourceSel <= srcSel_ff;
      intSourceConnect <= power_ff & ~srcExternal;
      refSourceSel <= refSel_ff;
      pgaEnable <= power_ff & refIsPga;
      pgaInputSel <= refIsPga ? pgaIn_ff : 2'h0;
      pgaGainSel <= refIsPga ? pgaGain_ff : 3'h0;
    end
  end

endmodule

/* src/adc_seq_map.vh */
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL_ZERO 8'h00
`define OFS_CTRL_ONE 8'h04
`define OFS_CTRL_TWO 8'h08
`define OFS_RES_HIGH 8'h0C
`define OFS_RES_LOW 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_MASK 8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define CZ_CHAN_LSB 0
`define CZ_FMT_BIT 4
`define CZ_START_BIT 5
`define CZ_BUSY_BIT 6
`define CZ_POWER_BIT 7
`define CO_DIV_LSB 0
`define CO_SRC_LSB 4
`define CT_REF_LSB 0
`define CT_PGAIN_LSB 2
`define CT_PGAGAIN_LSB 4
`define IS_DONE_BIT 0
`define IS_ABORT_BIT 1
`define IM_GLOBAL_BIT 7
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define CTRL_ZERO_RST 8'h00
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define INT_MASK_RST 8'h00
`define REF_PGA_CODE 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// timing counts in converter clocks, last phase index and result top bit mask
// ----------------------------------------
`define SAMPLE_CLKS 4'h4
`define CONV_CLKS 4'hC
`define LAST_PHASE 4'hF
`define RESULT_MSB_MASK 12'h800
`endif

/* tb/adc_core_model.sv */
`timescale 1ns/1ps
// -----------------
// analog core model
// -----------------
module adc_core_model (
  // clock and control
  input wire logic core_clk,
  input wire logic analogPowerOn,
  input wire logic sampleHold,
  // conversion path
  input wire logic [11:0] dacCode,
  input wire logic [11:0] level,
  output logic compIn
);
  logic [11:0] heldLvl;
  logic tgl = 1'b0;
  // track while sampling, hold afterwards
  always @(posedge core_clk) begin
    tgl <= ~tgl;
    if (sampleHold) begin
      heldLvl <= level;
    end
  end
  // comparator, scrambled while unpowered
  assign compIn = analogPowerOn ? (heldLvl >= dacCode) : tgl;
endmodule

/* tb/adc_seq_props.sv */
`timescale 1ns/1ps
// -------------------
// bus and core checks
// -------------------
module adc_seq_props (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // bus handshakes
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  // analog core
  input wire analogPowerOn,
  input wire sampleHold,
  input wire extChanConnect,
  input wire intSourceConnect,
  input wire pgaEnable,
  input wire [1:0] refSourceSel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // four sampling clocks at least
  sequence sampling_s;
    sampleHold [*4];
  endsequence
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped early");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  ar_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  input_route_a: assert property (((extChanConnect ^ intSourceConnect) == analogPowerOn) && !(extChanConnect && intSourceConnect))
    else $error("input routing wrong");
  pga_use_a: assert property (pgaEnable |-> refSourceSel == 2'h1)
    else $error("amplifier on without its reference");
  sample_len_a: assert property ($rose(sampleHold) |-> sampling_s)
    else $error("sampling too short");
  sample_pow_a: assert property (sampleHold |-> analogPowerOn)
    else $error("sampling while unpowered");
endmodule
bind adc_conversion_sequencer adc_seq_props adc_seq_props_i (
  .core_clk(core_clk), .rst_n(rst_n), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .analogPowerOn(analogPowerOn), .sampleHold(sampleHold), .pgaEnable(pgaEnable),
  .extChanConnect(extChanConnect), .intSourceConnect(intSourceConnect),
  .refSourceSel(refSourceSel)
);

/* tb/testbench.sv */
`timescale 1ns/1ps
// ----------------------
// sequencer bench
// ----------------------
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [11:0] level = 12'h000;
  wire awready, wready, bvalid, arready, rvalid, compIn, analogPowerOn, sampleHold;
  wire extChanConnect, intSourceConnect, pgaEnable, irq;
  wire [1:0] bresp, rresp, refSourceSel, pgaInputSel;
  wire [31:0] rdata;
  wire [11:0] dacCode;
  wire [3:0] extChanSel, intSourceSel;
  wire [2:0] pgaGainSel;
  int err_total = 0, checks = 0, cyc = 0;
  logic [1:0] r;
  logic [31:0] d;
  logic e;
  // clock and cycle count
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  adc_conversion_sequencer adc_conversion_sequencer_i (
    .core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .analogPowerOn(analogPowerOn), .sampleHold(sampleHold), .dacCode(dacCode),
    .compIn(compIn), .extChanSel(extChanSel), .extChanConnect(extChanConnect),
    .intSourceSel(intSourceSel), .intSourceConnect(intSourceConnect),
    .refSourceSel(refSourceSel), .pgaEnable(pgaEnable), .pgaInputSel(pgaInputSel),
    .pgaGainSel(pgaGainSel), .irq(irq)
  );
  adc_core_model adc_core_model_i (
    .core_clk(core_clk), .analogPowerOn(analogPowerOn), .sampleHold(sampleHold),
    .dacCode(dacCode), .level(level), .compIn(compIn)
  );
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    bound(n, 50);
  endtask
  // bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    bound(n, 50);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask
  // start high then low launches
  task automatic pulse(input logic fm);
    wr(8'h00, {3'h5, fm, 4'h3}, r);
    wr(8'h00, {3'h4, fm, 4'h3}, r);
  endtask
  // one timed conversion with result and status checks
  task automatic conv(input logic [2:0] dv, input logic fm, input logic [7:0] sts);
    int t0;
    wr(8'h04, {5'h00, dv}, r);
    pulse(fm);
    t0 = cyc;
    rchk(8'h00, {3'h6, fm, 4'h3});
    while (irq !== 1'b1 && cyc - t0 < 3000) @(posedge core_clk);
    bound(cyc - t0, 3000);
    chk(cyc - t0, 32'h10 << dv);
    chk(dacCode, level);
    rchk(8'h00, {3'h4, fm, 4'h3});
    rchk(8'h0C, fm ? {4'h0, level[11:8]} : level[11:4]);
    rchk(8'h10, fm ? level[7:0] : {level[3:0], 4'h0});
    rchk(8'h14, sts);
    @(posedge core_clk);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(i == 3 ? 8'h18 : 8'(i * 4), 32'h0);
    wr(8'h1C, 8'hFF, r);
    chk(r, 2'h2);
    rd(8'h1C, d, r);
    chk({r, d[7:0]}, 10'h200);
    $display("reset and map test done");
    wr(8'h00, 8'h86, r);
    for (int s = 0; s < 16; s++) begin
      wr(8'h04, {s[3:0], 4'h0}, r);
      @(posedge core_clk);
      e = (s == 0 || s == 4 || s >= 12);
      chk({extChanConnect, intSourceConnect}, {e, !e});
      chk(e ? extChanSel : intSourceSel, e ? 4'h6 : s[3:0]);
    end
    for (int f = 0; f < 4; f++) begin
      wr(8'h08, {4'h5, 2'h2, f[1:0]}, r);
      @(posedge core_clk);
      chk({pgaEnable, pgaGainSel, pgaInputSel, refSourceSel},
        f == 1 ? 8'hD9 : {6'h00, f[1:0]});
    end
    $display("routing test done");
    wr(8'h04, 8'h00, r);
    wr(8'h18, 8'h01, r);
    pulse(1'b0);
    repeat (40) @(posedge core_clk);
    chk(irq, 1'b0);
    rchk(8'h00, 8'h83);
    rchk(8'h14, 8'h01);
    wr(8'h18, 8'h81, r);
    for (int k = 0; k < 8; k++) begin
      level <= (k == 7) ? 12'hFFF : 12'h5A3 + 12'h111 * k[11:0];
      conv(k[2:0], k[0], 8'h01);
    end
    $display("conversion test done");
    wr(8'h04, 8'h03, r);
    pulse(1'b0);
    repeat (40) @(posedge core_clk);
    conv(3'h3, 1'b0, 8'h03);
    // power drop in mid conversion aborts, abort interrupt enabled
    wr(8'h18, 8'h82, r);
    pulse(1'b0);
    wr(8'h00, 8'h00, r);
    repeat (2) @(posedge core_clk);
    chk({analogPowerOn, extChanConnect, intSourceConnect}, 3'h0);
    chk(irq, 1'b1);
    rchk(8'h14, 8'h02);
    chk(irq, 1'b0);
    $display("abort and power test done");
    report_and_stop();
  end
endmodule
